/* rtl/adcsq_top.sv */
// adc sequencer with conversion data protection, sample fifo and wishbone slave
// assumes: one 250 MHz clock; front end pushes one code per conversion of chan_o;
// the auto_transfer_service pulses xfer_ack_i once it has moved result_o to memory
//
// Contract
// - one result register, rewritten at every completion unless protection holds it
// - completion with the previous result still pending pauses the sequencer
// - while paused, the new code is kept out of the result register
// - control low 9DH selects continuous scan, first channel 3, last channel 5
// - control low DBH selects stop mode on channel 3 alone
// - control high A4H picks external edge activation and arms the sequencer
// - every completion sets the done flag; the interrupt request follows it only while the interrupt enable is one
// - continuous mode wraps to first channel until busy is written zero
// - stop mode halts after each channel and waits for a new activation
// - protection pause only works while the interrupt enable is one
// - pause ends on transfer acknowledge or software clearing the done flag
`timescale 1ns/1ps
`include "adcsq_defines.svh"

module adcsq_fifo
  import adcsq_pkg::*;
#(
  parameter int WIDTH = `ADCSQ_CODE_W,
  parameter int DEPTH = `ADCSQ_FIFO_DEPTH
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        in_rdy;
  } adcsq_fifo_s;

  adcsq_fifo_s st;
  adcsq_fifo_s next_st;
  logic        push;
  logic        pop;

  always_comb
  begin
    next_st = st;
    push    = in_valid_i && st.in_rdy;
    pop     = out_ready_i && (st.cnt != '0);
    if (push)
    begin
      next_st.mem[st.wr] = in_data_i;
      next_st.wr         = st.wr + 1'b1;
    end
    if (pop)
      next_st.rd = st.rd + 1'b1;
    next_st.cnt    = st.cnt + CW'(push) - CW'(pop);
    // ready is registered so the front end sees a flop, at the cost of one
    // slot of lookahead being computed here from the next count
    next_st.in_rdy = (next_st.cnt != CW'(DEPTH));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st        <= '0;
      st.in_rdy <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign in_ready_o  = st.in_rdy;
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o  = st.mem[st.rd];
endmodule

module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     external_trigger_input_i,
  input  wire logic                     timer_trigger_i,
  input  wire logic                     sample_valid_i,
  input  wire logic [`ADCSQ_CODE_W-1:0] sample_data_i,
  output logic                          sample_ready_o,
  output logic      [`ADCSQ_CHAN_W-1:0] chan_o,
  output logic                          conv_active_o,
  output logic                          irq_o,
  output logic      [`ADCSQ_CODE_W-1:0] result_o,
  input  wire logic                     xfer_ack_i
);
  adcsq_top_s               st;
  adcsq_top_s               next_st;
  logic [7:0]               d;
  logic                     bus_req;
  logic                     wr_en;
  logic                     wr_low;
  logic                     wr_high;
  logic                     busy;
  logic                     paused;
  logic                     abort;
  logic                     clr_evt;
  logic                     pending;
  logic                     protect;
  adcsq_trig_e              trig_now;
  logic                     ext_edge;
  logic                     fire;
  logic                     pop_ok;
  logic                     fifo_vld;
  logic [`ADCSQ_CODE_W-1:0] fifo_code;
  logic                     done_vld;
  logic [`ADCSQ_CODE_W-1:0] done_code;
  logic                     last_hit;

  // codes wait here while the sequencer is paused, stalling the front end
  adcsq_fifo #(
    .WIDTH (`ADCSQ_CODE_W),
    .DEPTH (`ADCSQ_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (sample_valid_i),
    .in_data_i   (sample_data_i),
    .in_ready_o  (sample_ready_o),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_code),
    .out_ready_i (pop_ok)
  );

  always_comb
  begin
    next_st = st;
    d       = wb_dat_i[7:0];
    bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    wr_en   = bus_req && wb_we_i && wb_sel_i[0];
    wr_low  = wr_en && (wb_adr_i == `ADCSQ_ADR_CTRL_LOW);
    wr_high = wr_en && (wb_adr_i == `ADCSQ_ADR_CTRL_HIGH);
    busy    = (st.fsm != st_idle);
    paused  = (st.fsm == st_pause);
    abort   = wr_high && !d[`ADCSQ_BIT_BUSY] && busy;

    // pending result: set by completion, cleared by acknowledge or flag write
    clr_evt = xfer_ack_i || (wr_high && !d[`ADCSQ_BIT_INT]);
    pending = st.int_flag && !clr_evt;
    protect = st.conv_irq_enable && pending;

    // activation source: a control write takes effect in its own cycle
    trig_now = wr_high ? adcsq_trig_e'({d[`ADCSQ_BIT_STS_HI], d[`ADCSQ_BIT_STS_LO]}) : st.trig;
    ext_edge = st.sync2 && !st.sync3;
    fire     = (wr_high && d[`ADCSQ_BIT_START] && (trig_now == trg_soft))
            || (ext_edge && ((trig_now == trg_edge) || (trig_now == trg_both)))
            || (timer_trigger_i && ((trig_now == trg_timer) || (trig_now == trg_both)));

    next_st.sync1 = external_trigger_input_i;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    pop_ok    = (st.fsm == st_conv) && !abort;
    done_vld  = 1'b0;
    done_code = st.hold;
    last_hit  = (st.chan == st.low.last_channel_sel);

    case (st.fsm)
      st_idle:
      begin
        if (wr_high && d[`ADCSQ_BIT_BUSY])
        begin
          next_st.chan = st.low.first_channel_sel;
          next_st.fsm  = fire ? st_conv : st_wait;
        end
      end
      st_wait:
      begin
        if (fire)
          next_st.fsm = st_conv;
      end
      st_conv:
      begin
        if (pop_ok && fifo_vld)
        begin
          if (protect)
          begin
            next_st.hold = fifo_code;
            next_st.fsm  = st_pause;
          end
          else
          begin
            done_vld  = 1'b1;
            done_code = fifo_code;
          end
        end
      end
      st_pause:
      begin
        // dropping the enable also frees the pause; the held code then
        // lands untransferred, which software must avoid mid-transfer
        if (!protect)
          done_vld = 1'b1;
      end
      default:
      begin
        next_st.fsm = st_idle;
      end
    endcase

    if (done_vld)
    begin
      next_st.result = done_code;
      next_st.chan   = last_hit ? st.low.first_channel_sel : st.chan + `ADCSQ_CHAN_STEP;
      case (st.low.mode)
        md_cont:
          next_st.fsm = st_conv;
        md_stop:
          next_st.fsm = st_wait;
        default:
          next_st.fsm = last_hit ? st_idle : st_conv;
      endcase
    end

    // a forced stop drops any held code, unless its write also clears the done flag or a transfer acknowledge arrives with it, which lands the held code
    if (abort)
      next_st.fsm = st_idle;

    // set wins over a clear arriving in the same cycle
    if (done_vld)
      next_st.int_flag = 1'b1;
    else if (clr_evt)
      next_st.int_flag = 1'b0;

    if (wr_high)
    begin
      next_st.conv_irq_enable = d[`ADCSQ_BIT_CONV_IRQ_ENABLE];
      next_st.trig            = trig_now;
    end
    // scan layout only changes while stopped, so a scan never mixes settings
    if (wr_low && !busy)
      next_st.low = adcsq_low_s'(d);

    next_st.irq      = next_st.int_flag && next_st.conv_irq_enable;
    next_st.conv_act = (next_st.fsm == st_conv);

    next_st.ack  = bus_req;
    next_st.rdat = '0;
    if (bus_req && !wb_we_i)
    begin
      if (wb_adr_i == `ADCSQ_ADR_CTRL_LOW)
        next_st.rdat = 32'(st.low);
      else if (wb_adr_i == `ADCSQ_ADR_CTRL_HIGH)
        next_st.rdat = 32'({busy, st.int_flag, st.conv_irq_enable, paused, st.trig, 2'h0});
      else if (wb_adr_i == `ADCSQ_ADR_RESULT)
        next_st.rdat = 32'(st.result);
      else if (wb_adr_i == `ADCSQ_ADR_STATUS)
        next_st.rdat = 32'({st.chan, st.fsm});
      else
        next_st.rdat = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign wb_dat_o      = st.rdat;
  assign wb_ack_o      = st.ack;
  assign chan_o        = st.chan;
  assign conv_active_o = st.conv_act;
  assign irq_o         = st.irq;
  assign result_o      = st.result;
endmodule

/* rtl/adcsq_defines.svh */
// register offsets, field positions, reset values and sizes of the adc sequencer
// assumes: included by bare name from the package and from the design file
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

`define ADCSQ_ADR_CTRL_LOW  8'h00
`define ADCSQ_ADR_CTRL_HIGH 8'h04
`define ADCSQ_ADR_RESULT    8'h08
`define ADCSQ_ADR_STATUS    8'h0C

`define ADCSQ_BIT_BUSY      7
`define ADCSQ_BIT_INT       6
`define ADCSQ_BIT_CONV_IRQ_ENABLE      5
`define ADCSQ_BIT_PAUSED    4
`define ADCSQ_BIT_STS_HI    3
`define ADCSQ_BIT_STS_LO    2
`define ADCSQ_BIT_START     1

`define ADCSQ_RST_CTRL_LOW  8'h00
`define ADCSQ_CODE_W        10
`define ADCSQ_CHAN_W        3
`define ADCSQ_FIFO_DEPTH    16
`define ADCSQ_CHAN_STEP     3'h1

`endif

/* rtl/adcsq_pkg.sv */
// types shared by the adc sequencer and its sample fifo
// assumes: adcsq_defines.svh holds the channel and code widths used here
package adcsq_pkg;
  `include "adcsq_defines.svh"

  typedef enum logic [1:0] {
    md_single     = 2'b00,
    md_single_alt = 2'b01,
    md_cont       = 2'b10,
    md_stop       = 2'b11
  } adcsq_mode_e;

  typedef enum logic [1:0] {
    trg_soft  = 2'b00,
    trg_edge  = 2'b01,
    trg_timer = 2'b10,
    trg_both  = 2'b11
  } adcsq_trig_e;

  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_conv  = 2'b01,
    st_pause = 2'b10,
    st_wait  = 2'b11
  } adcsq_state_e;

  // conv_ctrl_low layout, msb first
  typedef struct packed {
    adcsq_mode_e               mode;
    logic [`ADCSQ_CHAN_W-1:0]  first_channel_sel;
    logic [`ADCSQ_CHAN_W-1:0]  last_channel_sel;
  } adcsq_low_s;

  typedef struct packed {
    adcsq_state_e              fsm;
    adcsq_low_s                low;
    logic                      conv_irq_enable;
    logic                      int_flag;
    adcsq_trig_e               trig;
    logic [`ADCSQ_CHAN_W-1:0]  chan;
    logic [`ADCSQ_CODE_W-1:0]  result;
    logic [`ADCSQ_CODE_W-1:0]  hold;
    logic                      ack;
    logic [31:0]               rdat;
    logic                      irq;
    logic                      conv_act;
    logic                      sync1;
    logic                      sync2;
    logic                      sync3;
  } adcsq_top_s;
endpackage

/* verification/adcsq_monitor.sv */
// port checker of the adc sequencer
// assumes: bound into adcsq_top, one clock, synchronous reset high
`timescale 1ns/1ps
`include "adcsq_defines.svh"
module adcsq_monitor
  import adcsq_pkg::*;
(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic                     xfer_ack_i,
  input wire logic                     irq_o,
  input wire logic                     conv_active_o,
  input wire logic [`ADCSQ_CHAN_W-1:0] chan_o,
  input wire logic [`ADCSQ_CODE_W-1:0] result_o
);
  logic wbx;
  assign wbx = wb_cyc_i & wb_stb_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_lat; wbx && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("no ack after request");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_rd_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside ack");
  // a pending result must not be overwritten before it is moved
  property p_protect; irq_o && !xfer_ack_i && !wbx |=> $stable(result_o); endproperty
  a_protect: assert property (p_protect) else $error("result overwritten while pending");
  property p_flag_keep; irq_o && !xfer_ack_i && !wbx |=> irq_o; endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("request dropped without clear");
  property p_irq_cause; $rose(irq_o) && !$past(wbx) |-> $past(conv_active_o); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without conversion");
  property p_chan_still;
    !conv_active_o && !$past(conv_active_o) && !$past(wbx) && !$past(xfer_ack_i) |-> $stable(chan_o);
  endproperty
  a_chan_still: assert property (p_chan_still) else $error("channel moved while halted");
  property p_relflag;
    $past(irq_o) && $past(xfer_ack_i) && !$past(wbx) && $changed(result_o) |-> irq_o;
  endproperty
  a_relflag: assert property (p_relflag) else $error("released word not flagged");
  c_release: cover property (irq_o && xfer_ack_i);
  c_start: cover property ($rose(conv_active_o));
  c_halt: cover property ($fell(conv_active_o) && irq_o);
endmodule

bind adcsq_top adcsq_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xfer_ack_i(xfer_ack_i), .irq_o(irq_o),
  .conv_active_o(conv_active_o), .chan_o(chan_o), .result_o(result_o));

/* verification/adcsq_xfer_model.sv */
// model of the automatic transfer service moving result words to memory
// assumes: same clock as the sequencer; answers dly_i plus one cycles after the request
`timescale 1ns/1ps
`include "adcsq_defines.svh"
module adcsq_xfer_model
  import adcsq_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     en_i,
  input  wire logic [7:0]               dly_i,
  input  wire logic                     irq_i,
  input  wire logic [`ADCSQ_CODE_W-1:0] word_i,
  output logic                          ack_o,
  output logic      [`ADCSQ_CODE_W-1:0] mem_o [16],
  output int                            cnt_o
);
  logic [7:0] wait_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o  <= 1'b0;
      wait_q <= 8'h00;
      cnt_o  <= 0;
    end
    else if (ack_o)
    begin
      ack_o  <= 1'b0;
      wait_q <= 8'h00; // skip a cycle so the request level can settle
    end
    else if (irq_i && en_i && wait_q >= dly_i)
    begin
      ack_o             <= 1'b1;
      mem_o[cnt_o[3:0]] <= word_i;
      cnt_o             <= cnt_o + 1;
    end
    else
    begin
      ack_o <= 1'b0;
      if (irq_i && en_i)
        wait_q <= wait_q + 8'h01;
    end
  end
endmodule

/* verification/tb_adcsq_top.sv */
// self-checking bench of the adc sequencer with data protection
// assumes: package, design and transfer model compiled first
`timescale 1ns/1ps
module tb_adcsq_top
  import adcsq_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pin = 1'b0, sv = 1'b0, en = 1'b1;
  logic        xack, ack, irq, act, rdy;
  logic [7:0]  adr = 8'h00, dly = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [9:0]  sd = 10'h000, res;
  logic [9:0]  mem [16];
  logic [2:0]  ch;
  int          cnt, fail_count = 0, checked = 0, cyc_n = 0;
  adcsq_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack), .external_trigger_input_i(pin),
    .timer_trigger_i(1'b0), .sample_valid_i(sv), .sample_data_i(sd), .sample_ready_o(rdy), .chan_o(ch),
    .conv_active_o(act), .irq_o(irq), .result_o(res), .xfer_ack_i(xack));
  adcsq_xfer_model u_xfer (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .dly_i(dly), .irq_i(irq), .word_i(res),
    .ack_o(xack), .mem_o(mem), .cnt_o(cnt));
  initial
    forever #2 clk_i = ~clk_i;
  task automatic results;
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // every scenario ends well inside this ceiling
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wd <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = q;
    cyc <= 1'b0;
  endtask
  task automatic push(input logic [9:0] d);
    @(posedge clk_i);
    sv <= 1'b1; sd <= d;
    do @(posedge clk_i); while (rdy !== 1'b1);
    sv <= 1'b0;
  endtask
  task automatic trig;
    @(posedge clk_i);
    pin <= 1'b1;
    repeat (4) @(posedge clk_i);
    pin <= 1'b0;
  endtask
  task automatic wait_res(input logic [9:0] e);
    for (int i = 0; i < 300 && res !== e; i++) @(posedge clk_i);
    chk("result", e, res);
  endtask
  task automatic sc_cont;
    dly <= 8'd40; // a slow transfer forces the pause
    wb(1'b1, 8'h00, 8'h9D);
    wb(1'b0, 8'h00, 8'h00);
    chk("ctrl_low", 10'h09D, rd[9:0]);
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped", 10'h000, rd[9:0]);
    wb(1'b1, 8'h04, 8'hA4);
    trig();
    push(10'h1A1); push(10'h2B2); push(10'h3C3);
    wait_res(10'h1A1);
    repeat (20) @(posedge clk_i);
    chk("held", 10'h1A1, res);
    for (int i = 0; i < 400 && cnt < 3; i++) @(posedge clk_i);
    chk("word0", 10'h1A1, mem[0]);
    chk("word1", 10'h2B2, mem[1]);
    chk("word2", 10'h3C3, mem[2]);
    chk("wrap", 10'h003, {7'h0, ch});
    wb(1'b1, 8'h04, 8'h20);
    chk("active", 10'h000, {9'h0, act});
    chk("kept", 10'h3C3, res);
    wb(1'b0, 8'h08, 8'h00);
    chk("result_reg", 10'h3C3, rd[9:0]);
  endtask
  task automatic sc_stop;
    dly <= 8'd0;
    wb(1'b1, 8'h00, 8'hDB);
    wb(1'b1, 8'h04, 8'hA4);
    trig();
    push(10'h155);
    wait_res(10'h155);
    chk("halt", 10'h000, {9'h0, act});
    chk("chan", 10'h003, {7'h0, ch});
    push(10'h0AA);
    repeat (30) @(posedge clk_i);
    chk("idle", 10'h155, res);
    chk("word3", 10'h155, mem[3]);
    trig();
    wait_res(10'h0AA);
    wb(1'b1, 8'h04, 8'h20);
  endtask
  task automatic sc_soft;
    en <= 1'b0; // software alone releases the pause
    wb(1'b1, 8'h00, 8'h9D);
    wb(1'b1, 8'h04, 8'hA4);
    trig();
    push(10'h011); push(10'h022);
    wait_res(10'h011);
    repeat (20) @(posedge clk_i);
    chk("held", 10'h011, res);
    chk("irq", 10'h001, {9'h0, irq});
    wb(1'b0, 8'h04, 8'h00);
    chk("paused", 10'h0F4, rd[9:0]);
    wb(1'b1, 8'h04, 8'hA4);
    wait_res(10'h022);
    for (int i = 0; i < 17; i++) push(10'h100 + 10'(i));
    repeat (4) @(posedge clk_i);
    chk("full", 10'h000, {9'h0, rdy});
    wb(1'b1, 8'h04, 8'h84);
    wait_res(10'h110);
    chk("empty", 10'h001, {9'h0, rdy});
    chk("irq_off", 10'h000, {9'h0, irq});
    wb(1'b1, 8'h04, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_cont();
    sc_stop();
    sc_soft();
    results();
  end
endmodule
